// ==== pkg/md_map.svh ====
`ifndef MD_MAP_SVH
`define MD_MAP_SVH
// ****************************************
// Timing
// ****************************************
`define CLK_NS 100
`define MC_NS 950
`define MC_CLKS ((`MC_NS + `CLK_NS - 1) / `CLK_NS)
`define CYC_MD 10
`define CYC_MD_EXT 11
`define CYC_LDST 3
`define CYC_INR 4
`define CYC_ALU 3
// ****************************************
// Instruction decode
// ****************************************
`define OP_PROD 4'hE
`define OP_QUOT 4'hF
`define EXT_PFX 7'h06
`define MODE_REL_P 3'h4
`define MODE_IDX_X 3'h5
`define MODE_IDX_B 3'h6
`define MODE_IND 3'h7
`define FN_INR 3'h4
`define FN_OR 3'h1
`define FN_ADD 3'h2
`define FN_XOR 3'h3
`define FN_SUB 3'h4
`define FN_AND 3'h5
`define FN_PROD 3'h6
`define FN_QUOT 3'h7
`define SHIFT_CODE 4'hF
`define LAST_COUNT 4'hF
// ****************************************
// Register port
// ****************************************
`define REG_CTRL 2'h0
`define REG_STAT 2'h1
`define REG_EA 2'h2
`define REG_SHIFT 2'h3
`define CTRL_EN 0
`define ST_BUSY 0
`define ST_OVF 1
`define ST_NEG 2
`define ST_ADDOP 3
`define ST_ASIGN 4
`define ST_LAST 5
`define ST_DSC 6
`endif

// ==== pkg/md_pkg.sv ====
package md_pkg;

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_RD, S_RDW, S_SETUP, S_SHIFT, S_CORR, S_EXEC,
    S_WR, S_FIN, S_PAD
  } state_e;

  typedef enum logic [2:0] {
    K_NONE, K_MUL, K_DIV, K_LD, K_ST, K_INR, K_ALU
  } kind_e;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] x;
    logic [15:0] p;
  } core_regs_s;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] x;
    logic        ld_a;
    logic        ld_b;
    logic        ld_x;
  } result_s;

endpackage

// ==== design/md_step.sv ====
`timescale 1ns/10ps
`default_nettype none
module md_step
(
  input  wire logic [15:0] a,
  input  wire logic [15:0] r,
  input  wire logic        div_add,
  input  wire logic        qneg,
  input  wire logic        neg,
  output logic      [15:0] mul_a,
  output logic             mul_lo,
  output logic      [15:0] div_sum,
  output logic             applied,
  output logic             qbit,
  output logic             dsc
);
  logic [16:0] psum;
  logic        povf;

  always_comb
  begin
    psum = {a[15], a} + {r[15], r};
    povf = psum[16] ^ psum[15];
    // Overflowed sum keeps its true sign in the partial product
    mul_a = {(povf ? ~psum[15] : psum[15]), psum[15:1]};
    mul_lo = psum[0];
    div_sum = div_add ? a + r : a - r;
    applied = div_sum[15] == a[15];
    qbit = applied ^ qneg;
    dsc = div_sum[15] ^ neg;
  end
endmodule // md_step
`default_nettype wire

// ==== design/md_ext_unit.sv ====
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "md_map.svh"
module md_ext_unit
(
  input  wire logic               CLOCK,
  input  wire logic               RST_B,
  input  wire logic [1:0]         REG_ADDR,
  input  wire logic [15:0]        REG_WDATA,
  input  wire logic               REG_WR,
  input  wire logic               REG_RD,
  output logic      [15:0]        REG_RDATA,
  input  wire logic               START,
  input  wire logic [15:0]        INSTR,
  input  wire logic [15:0]        WORD2,
  input  wire md_pkg::core_regs_s CORE,
  input  wire logic               EXT_INHIBIT,
  output logic                    MEM_RD,
  output logic                    MEM_WR,
  output logic      [14:0]        MEM_ADDR,
  output logic      [15:0]        MEM_WDATA,
  input  wire logic [15:0]        MEM_RDATA,
  output md_pkg::result_s         RESULT,
  output logic                    DONE,
  output logic                    BUSY,
  output logic                    OVERFLOW
);
  // ****************************************
  // Sequencer state
  // ****************************************
  typedef struct packed {
    md_pkg::state_e  state;
    md_pkg::kind_e   kind;
    logic [2:0]      fn;
    logic [2:0]      mode;
    logic            ext;
    logic [15:0]     ir;
    logic [15:0]     w2;
    logic [15:0]     a;
    logic [15:0]     b;
    logic [15:0]     x;
    logic [15:0]     p;
    logic [15:0]     r;
    logic [15:0]     wd;
    logic [14:0]     maddr;
    logic            ind;
    logic [3:0]      sc;
    logic [7:0]      cnt;
    logic [7:0]      tgt;
    logic            neg;
    logic            addop;
    logic            asign;
    logic            adden;
    logic            lsc;
    logic            shc;
    logic            shf;
    logic            last;
    logic            bis;
    logic            dsc;
    logic            first;
    logic            spill;
    logic            ovf;
    logic            en;
    md_pkg::result_s res;
    logic            done;
    logic [15:0]     rdata;
  } ctx_s;

  ctx_s s;
  ctx_s n;

  logic          is_ext;
  md_pkg::kind_e dkind;
  logic [7:0]    dtgt;
  logic [15:0]   st_mul_a;
  logic          st_mul_lo;
  logic [15:0]   st_sum;
  logic          st_applied;
  logic          st_q;
  logic          st_dsc;
  logic          operand_select_in_division;
  logic [15:0]   ea_base;
  logic [15:0]   alu_sum;
  logic [15:0]   corr;

  assign is_ext = INSTR[15:9] == `EXT_PFX && INSTR[8:7] == 2'h0;
  // Divisor goes in as an addend only with all four terms present
  assign operand_select_in_division = s.kind == md_pkg::K_DIV && s.shf
                                      && s.addop && s.adden;

  // ****************************************
  // Decode
  // ****************************************
  always_comb
  begin
    dkind = md_pkg::K_NONE;
    dtgt = 8'(`CYC_MD * `MC_CLKS);
    if (INSTR[15:12] == `OP_PROD)
      dkind = md_pkg::K_MUL;
    else if (INSTR[15:12] == `OP_QUOT)
      dkind = md_pkg::K_DIV;
    else if (is_ext && !INSTR[6])
    begin
      unique case (INSTR[5:3])
        3'h0: dkind = md_pkg::K_NONE;
        3'h1, 3'h2, 3'h3: dkind = md_pkg::K_LD;
        `FN_INR: dkind = md_pkg::K_INR;
        default: dkind = md_pkg::K_ST;
      endcase
    end
    else if (is_ext)
    begin
      unique case (INSTR[5:3])
        3'h0: dkind = md_pkg::K_NONE;
        `FN_PROD: dkind = md_pkg::K_MUL;
        `FN_QUOT: dkind = md_pkg::K_DIV;
        default: dkind = md_pkg::K_ALU;
      endcase
    end
    if (is_ext)
    begin
      unique case (dkind)
        md_pkg::K_MUL, md_pkg::K_DIV: dtgt = 8'(`CYC_MD_EXT * `MC_CLKS);
        md_pkg::K_INR: dtgt = 8'(`CYC_INR * `MC_CLKS);
        md_pkg::K_ALU: dtgt = 8'(`CYC_ALU * `MC_CLKS);
        default: dtgt = 8'(`CYC_LDST * `MC_CLKS);
      endcase
    end
  end

  md_step u_step
  (
    .a       (s.a),
    .r       (s.r),
    .div_add (operand_select_in_division),
    .qneg    (s.addop),
    .neg     (s.neg),
    .mul_a   (st_mul_a),
    .mul_lo  (st_mul_lo),
    .div_sum (st_sum),
    .applied (st_applied),
    .qbit    (st_q),
    .dsc     (st_dsc)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    n = s;
    n.done = 1'b0;
    n.cnt = s.cnt + 8'h01;
    unique case (s.mode)
      `MODE_REL_P: ea_base = s.w2 + s.p + 16'h0001;
      `MODE_IDX_X: ea_base = s.w2 + s.x;
      `MODE_IDX_B: ea_base = s.w2 + s.b;
      default: ea_base = s.w2;
    endcase
    alu_sum = (s.fn == `FN_SUB) ? s.a - s.r : s.a + s.r;
    corr = s.a - s.r;
    if (REG_WR && REG_ADDR == `REG_CTRL)
      n.en = REG_WDATA[`CTRL_EN];
    // Clear first so that a hardware set in this cycle wins
    if (REG_WR && REG_ADDR == `REG_STAT && REG_WDATA[`ST_OVF])
      n.ovf = 1'b0;
    n.rdata = 16'h0000;
    if (REG_RD)
    begin
      unique case (REG_ADDR)
        `REG_CTRL: n.rdata[`CTRL_EN] = s.en;
        `REG_STAT:
        begin
          n.rdata[`ST_BUSY] = s.state != md_pkg::S_IDLE;
          n.rdata[`ST_OVF] = s.ovf;
          n.rdata[`ST_NEG] = s.neg;
          n.rdata[`ST_ADDOP] = s.addop;
          n.rdata[`ST_ASIGN] = s.asign;
          n.rdata[`ST_LAST] = s.last;
          n.rdata[`ST_DSC] = s.dsc;
        end
        `REG_EA: n.rdata = {1'b0, s.maddr};
        `REG_SHIFT: n.rdata = {12'h000, s.sc};
      endcase
    end
    unique case (s.state)
      md_pkg::S_IDLE:
      begin
        n.cnt = 8'h00;
        // Extended forms are held off while traps or DMA own the bus
        if (START && s.en && dkind != md_pkg::K_NONE
            && !(is_ext && EXT_INHIBIT))
        begin
          n.kind = dkind;
          n.tgt = dtgt;
          n.ext = is_ext;
          n.fn = INSTR[5:3];
          n.mode = INSTR[2:0];
          n.ir = INSTR;
          n.w2 = WORD2;
          n.a = CORE.a;
          n.b = CORE.b;
          n.x = CORE.x;
          n.p = CORE.p;
          n.asign = CORE.a[15];
          n.res.ld_a = 1'b0;
          n.res.ld_b = 1'b0;
          n.res.ld_x = 1'b0;
          n.sc = 4'h0;
          n.last = 1'b0;
          n.first = 1'b1;
          n.ind = 1'b0;
          if (!is_ext)
          begin
            // One-word form: low field is the operand address
            n.maddr = {3'h0, INSTR[11:0]};
            n.state = md_pkg::S_RD;
          end
          else if (INSTR[2] == 1'b0 && dkind != md_pkg::K_ST)
          begin
            n.r = WORD2;
            n.state = (dkind == md_pkg::K_MUL || dkind == md_pkg::K_DIV)
                      ? md_pkg::S_SETUP : md_pkg::S_EXEC;
          end
          else
            n.state = md_pkg::S_ADDR;
        end
      end
      md_pkg::S_ADDR:
      begin
        n.maddr = ea_base[14:0];
        n.ind = s.mode == `MODE_IND && s.w2[15];
        n.state = (s.kind == md_pkg::K_ST && !n.ind) ? md_pkg::S_WR
                  : md_pkg::S_RD;
        unique case (s.fn[1:0])
          2'h1: n.wd = s.a;
          2'h2: n.wd = s.b;
          default: n.wd = s.x;
        endcase
      end
      md_pkg::S_RD: n.state = md_pkg::S_RDW;
      md_pkg::S_RDW:
      begin
        if (s.ind)
        begin
          // Each indirect level costs one more machine cycle
          n.maddr = MEM_RDATA[14:0];
          n.ind = MEM_RDATA[15];
          n.tgt = s.tgt + 8'(`MC_CLKS);
          n.state = (s.kind == md_pkg::K_ST && !MEM_RDATA[15])
                    ? md_pkg::S_WR : md_pkg::S_RD;
        end
        else
        begin
          n.r = MEM_RDATA;
          n.state = (s.kind == md_pkg::K_MUL || s.kind == md_pkg::K_DIV)
                    ? md_pkg::S_SETUP : md_pkg::S_EXEC;
        end
      end
      md_pkg::S_SETUP:
      begin
        n.ir[8:5] = `SHIFT_CODE;
        n.shc = 1'b1;
        n.shf = 1'b1;
        n.lsc = 1'b1;
        n.state = md_pkg::S_SHIFT;
        if (s.kind == md_pkg::K_MUL)
        begin
          n.neg = s.b[15];
          n.b[15] = 1'b0;
          n.adden = s.b[0];
        end
        else
        begin
          n.neg = s.asign;
          n.addop = s.asign ^ s.r[15];
          n.adden = 1'b1;
          n.spill = 1'b0;
          if (s.r == 16'h0000)
          begin
            n.b = {~s.a[15], ~s.a[14:0]};
            n.a = {s.asign, s.b[14:0]};
            n.ovf = 1'b1;
            n.state = md_pkg::S_FIN;
          end
        end
      end
      md_pkg::S_SHIFT:
      begin
        if (s.kind == md_pkg::K_MUL && s.lsc)
        begin
          n.a = s.adden ? st_mul_a : {s.a[15], s.a[15:1]};
          n.bis = s.adden ? st_mul_lo : s.a[0];
          n.lsc = 1'b0;
        end
        else if (s.kind == md_pkg::K_MUL)
        begin
          n.b = {1'b0, s.bis, s.b[14:1]};
          n.adden = s.b[1];
          n.sc = s.sc + 4'h1;
          n.lsc = 1'b1;
          if (s.sc == `LAST_COUNT - 4'h1)
          begin
            n.last = 1'b1;
            n.state = md_pkg::S_CORR;
          end
        end
        else if (s.lsc)
        begin
          n.first = 1'b0;
          if (s.first)
            n.dsc = st_dsc;
          // Divisor fits into the unshifted high part: quotient too big
          if (s.first && st_applied)
            n.ovf = 1'b1;
          // A bit spilled past the sign means the divisor surely fits
          n.a = (st_applied || s.spill) ? {s.asign, st_sum[14:0]}
                : s.a;
          n.bis = st_q ^ s.spill;
          n.adden = st_applied || s.spill;
          n.lsc = 1'b0;
        end
        else
        begin
          // Last pass moves the final difference without a shift
          if (!s.last)
            n.a = {s.asign, s.a[13:0], s.b[14]};
          // Remainders above half the range lose bit 14 in the shift
          n.spill = !s.last && s.a[14] != s.asign;
          n.b = {1'b0, s.b[13:0], s.bis};
          n.sc = s.sc + 4'h1;
          n.lsc = 1'b1;
          n.adden = 1'b1;
          if (s.last)
            n.state = md_pkg::S_CORR;
          else if (s.sc == `LAST_COUNT - 4'h1)
            n.last = 1'b1;
        end
      end
      md_pkg::S_CORR:
      begin
        n.shc = 1'b0;
        n.shf = 1'b0;
        n.lsc = 1'b0;
        n.state = md_pkg::S_FIN;
        if (s.kind == md_pkg::K_MUL && s.neg)
        begin
          n.a = corr;
          if (s.a[15] != s.r[15] && corr[15] != s.a[15])
            n.ovf = 1'b1;
        end
        else if (s.kind == md_pkg::K_DIV)
        begin
          n.b = {s.addop, s.b[14:0]} + {15'h0000, s.addop};
          n.a[15] = s.asign;
        end
      end
      md_pkg::S_FIN:
      begin
        n.res.a = s.a;
        n.res.b = s.b;
        n.res.ld_a = 1'b1;
        n.res.ld_b = 1'b1;
        n.state = md_pkg::S_PAD;
      end
      md_pkg::S_EXEC:
      begin
        n.state = md_pkg::S_PAD;
        unique case (s.kind)
          md_pkg::K_LD:
          begin
            n.res.a = s.r;
            n.res.b = s.r;
            n.res.x = s.r;
            n.res.ld_a = s.fn[1:0] == 2'h1;
            n.res.ld_b = s.fn[1:0] == 2'h2;
            n.res.ld_x = s.fn[1:0] == 2'h3;
          end
          md_pkg::K_INR:
          begin
            n.wd = s.r + 16'h0001;
            n.state = md_pkg::S_WR;
          end
          default:
          begin
            n.res.ld_a = 1'b1;
            unique case (s.fn)
              `FN_OR: n.res.a = s.a | s.r;
              `FN_XOR: n.res.a = s.a ^ s.r;
              `FN_AND: n.res.a = s.a & s.r;
              default:
              begin
                n.res.a = alu_sum;
                if ((s.fn == `FN_SUB ? s.a[15] != s.r[15]
                     : s.a[15] == s.r[15]) && alu_sum[15] != s.a[15])
                  n.ovf = 1'b1;
              end
            endcase
          end
        endcase
      end
      md_pkg::S_WR: n.state = md_pkg::S_PAD;
      md_pkg::S_PAD:
      begin
        // Completion is paced to the documented machine-cycle count
        if (s.cnt >= s.tgt - 8'h02)
        begin
          n.done = 1'b1;
          n.state = md_pkg::S_IDLE;
        end
      end
      default: n.state = md_pkg::S_IDLE;
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge CLOCK)
  begin
    if (!RST_B)
    begin
      s <= '0;
      s.en <= 1'b1;
    end
    else
      s <= n;
  end

  assign REG_RDATA = s.rdata;
  assign MEM_RD = s.state == md_pkg::S_RD;
  assign MEM_WR = s.state == md_pkg::S_WR;
  assign MEM_ADDR = s.maddr;
  assign MEM_WDATA = s.wd;
  assign RESULT = s.res;
  assign DONE = s.done;
  assign BUSY = s.state != md_pkg::S_IDLE;
  assign OVERFLOW = s.ovf;
endmodule // md_ext_unit
`default_nettype wire

// ==== sim/md_ext_unit_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "md_map.svh"
module md_ext_unit_checker
(
  input wire logic        CLOCK,
  input wire logic        RST_B,
  input wire logic [1:0]  REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic        START,
  input wire logic        MEM_RD,
  input wire logic        MEM_WR,
  input wire logic        DONE,
  input wire logic        BUSY,
  input wire logic        OVERFLOW
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);

  sequence s_quiet8;
    !DONE [*8];
  endsequence
  // Clear only asserted while idle, so no completion can race it
  sequence s_clear_idle;
    REG_WR && REG_ADDR == `REG_STAT && REG_WDATA[`ST_OVF] && !BUSY && !DONE;
  endsequence

  property p_done_pulse;
    DONE |=> !DONE;
  endproperty
  property p_op_span;
    $rose(BUSY) |-> s_quiet8 ##1 s_quiet8 ##1 s_quiet8 ##[1:400] DONE;
  endproperty
  property p_busy_cause;
    $rose(BUSY) |-> $past(START);
  endproperty
  property p_done_from_busy;
    DONE |-> $past(BUSY);
  endproperty
  property p_stat_read;
    REG_RD && REG_ADDR == `REG_STAT |=> REG_RDATA[`ST_BUSY] == $past(BUSY)
      && REG_RDATA[`ST_OVF] == $past(OVERFLOW);
  endproperty
  property p_ovf_clear;
    s_clear_idle |=> !OVERFLOW;
  endproperty
  property p_ovf_sticky;
    OVERFLOW && !(REG_WR && REG_ADDR == `REG_STAT && REG_WDATA[`ST_OVF])
      |=> OVERFLOW;
  endproperty
  property p_mem_excl;
    !(MEM_RD && MEM_WR);
  endproperty
  property p_mem_in_op;
    MEM_RD || MEM_WR |-> BUSY;
  endproperty

  a_done_pulse: assert property (p_done_pulse)
    else $error("done held past one cycle");
  a_op_span: assert property (p_op_span)
    else $error("operation length out of range");
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy rose without a start");
  a_done_from_busy: assert property (p_done_from_busy)
    else $error("done without an operation");
  a_stat_read: assert property (p_stat_read)
    else $error("status read differs from port state");
  a_ovf_clear: assert property (p_ovf_clear)
    else $error("overflow not cleared");
  a_ovf_sticky: assert property (p_ovf_sticky)
    else $error("overflow dropped by itself");
  a_mem_excl: assert property (p_mem_excl)
    else $error("memory read and write together");
  a_mem_in_op: assert property (p_mem_in_op)
    else $error("memory access while idle");
endmodule // md_ext_unit_checker
bind md_ext_unit md_ext_unit_checker u_chk (.CLOCK(CLOCK), .RST_B(RST_B),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .START(START), .MEM_RD(MEM_RD),
  .MEM_WR(MEM_WR), .DONE(DONE), .BUSY(BUSY), .OVERFLOW(OVERFLOW));
`default_nettype wire

// ==== sim/md_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module md_mem_model
(
  input  wire logic        clock,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [14:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata
);
  logic [15:0] mem [0:32767];
  // Read data stands one cycle, then turns over so a late sample shows
  always @(posedge clock)
  begin
    if (mem_wr)
      mem[mem_addr] <= mem_wdata;
    if (mem_rd)
      mem_rdata <= mem[mem_addr];
    else
      mem_rdata <= ~mem_rdata;
  end
endmodule // md_mem_model
`default_nettype wire

// ==== sim/multiply_divide_ext_addr_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "md_map.svh"
module multiply_divide_ext_addr_test;
  logic               clock = 1'b0;
  logic               rst_b = 1'b0;
  logic [1:0]         reg_addr = 2'h0;
  logic [15:0]        reg_wdata = 16'h0000;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic               start = 1'b0;
  logic [15:0]        instr = 16'h0000;
  logic [15:0]        word2 = 16'h0000;
  md_pkg::core_regs_s core = '0;
  logic               inhibit = 1'b0;
  logic [15:0]        reg_rdata, mem_wdata, mem_rdata;
  logic               mem_rd, mem_wr, done, busy, overflow;
  logic [14:0]        mem_addr;
  md_pkg::result_s    res;
  logic [31:0]        seed = 32'h000000EB;
  int                 bad_count = 0;
  int                 total_checks = 0;
  int                 ticks = 0;

  always #50 clock = ~clock;

  md_ext_unit DUT (.CLOCK(clock), .RST_B(rst_b), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .START(start), .INSTR(instr), .WORD2(word2),
    .CORE(core), .EXT_INHIBIT(inhibit), .MEM_RD(mem_rd), .MEM_WR(mem_wr),
    .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata),
    .RESULT(res), .DONE(done), .BUSY(busy), .OVERFLOW(overflow));
  md_mem_model mem_u (.clock(clock), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] ext(input logic [2:0] g,
                                      input logic [2:0] f,
                                      input logic [2:0] m);
    return {`EXT_PFX, g, f, m};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check16(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // A zero cycle count means the start must be refused
  task automatic run(input logic [15:0] ins, input logic [15:0] w2,
                     input md_pkg::core_regs_s c, input int cyc,
                     input logic poke);
    int n;
    // The take edge counts as the first cycle of the operation
    n = 1;
    @(posedge clock);
    instr <= ins;
    word2 <= w2;
    core <= c;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    do
    begin
      @(posedge clock);
      n++;
      start <= poke && n == 5;
      #1;
    end
    while (done !== 1'b1 && n < (cyc == 0 ? 150 : 400));
    check16("cycles", cyc == 0 ? 16'h0096 : cyc[15:0], n[15:0]);
  endtask

  always @(posedge clock)
  begin
    ticks <= ticks + 1;
    if (ticks == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    md_pkg::core_regs_s c;
    logic [31:0]        r;
    logic [15:0]        w, d, ad, ea, eb;
    logic signed [63:0] pr;
    int                 i;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      bus_rd(i[1:0], d);
      check16("reg_reset", i == 0 ? 16'h0001 : 16'h0000, d);
    end
    $display("test reset done");
    for (i = 1; i < 8; i++)
    begin
      c = {rnd(), rnd()};
      r = rnd();
      w = {1'b0, r[14:0]};
      d = r[31:16];
      mem_u.mem[w[14:0]] = d;
      run(ext(3'h0, i[2:0], `MODE_IND), w, c, (i == 4 ? `CYC_INR
          : `CYC_LDST) * `MC_CLKS, i == 2);
      check16("ld_bits", {13'h0000, i == 1, i == 2, i == 3},
              {13'h0000, res.ld_a, res.ld_b, res.ld_x});
      case (i)
        1: check16("ld_a", d, res.a);
        2: check16("ld_b", d, res.b);
        3: check16("ld_x", d, res.x);
        4: check16("inr", d + 16'h0001, mem_u.mem[w[14:0]]);
        5: check16("st_a", c.a, mem_u.mem[w[14:0]]);
        6: check16("st_b", c.b, mem_u.mem[w[14:0]]);
        default: check16("st_x", c.x, mem_u.mem[w[14:0]]);
      endcase
      if (i == 1)
      begin
        bus_rd(`REG_EA, ad);
        check16("ea", w, ad);
      end
    end
    $display("test load store done");
    for (i = 0; i < 8; i++)
    begin
      c = {rnd(), rnd()};
      r = rnd();
      w = {1'b0, r[14:0]};
      d = r[31:16];
      case (i[2:0])
        `MODE_REL_P: ad = w + c.p + 16'h0001;
        `MODE_IDX_X: ad = w + c.x;
        `MODE_IDX_B: ad = w + c.b;
        default: ad = w;
      endcase
      mem_u.mem[ad[14:0]] = d;
      run(ext(3'h0, 3'h1, i[2:0]), w, c, `CYC_LDST * `MC_CLKS, 1'b0);
      check16("mode", i < 4 ? w : d, res.a);
    end
    mem_u.mem[15'h0123] = 16'h0456;
    mem_u.mem[15'h0456] = 16'hBEEF;
    run(ext(3'h0, 3'h1, `MODE_IND), 16'h8123, c,
        (`CYC_LDST + 1) * `MC_CLKS, 1'b0);
    check16("indirect", 16'hBEEF, res.a);
    $display("test modes done");
    for (i = 1; i < 6; i++)
    begin
      c = {rnd(), rnd()};
      r = rnd();
      w = {1'b0, r[14:0]};
      d = r[31:16];
      mem_u.mem[w[14:0]] = d;
      case (i)
        1: ea = c.a | d;
        2: ea = c.a + d;
        3: ea = c.a ^ d;
        4: ea = c.a - d;
        default: ea = c.a & d;
      endcase
      run(ext(3'h1, i[2:0], `MODE_IND), w, c, `CYC_ALU * `MC_CLKS, 1'b0);
      check16("alu", ea, res.a);
    end
    $display("test logic arith done");
    for (i = 0; i < 12; i++)
    begin
      r = rnd();
      c = {rnd(), rnd()};
      d = r[15:0];
      w = {4'h0, r[27:16]};
      if (i % 2 == 1)
      begin
        d = {1'b0, d[14:1], 1'b1};
        c.a = c.a % d;
      end
      else if (c.b == 16'h8000)
        c.b = 16'h7FFF;
      if (i == 0)
      begin
        c = {16'h0000, 16'hFFC8, c.x, c.p};
        d = 16'h04BC;
      end
      if (i == 1)
      begin
        c = {16'hFFFF, 16'h7B2E, c.x, c.p};
        d = 16'h0268;
      end
      mem_u.mem[w[14:0]] = d;
      if (i % 2 == 0)
      begin
        pr = 64'($signed(c.a)) + 64'($signed(c.b)) * 64'($signed(d));
        ea = pr[30:15];
        eb = {1'b0, pr[14:0]};
      end
      else
      begin
        pr = 64'($signed({c.a, c.b[14:0]}));
        ea = 16'(pr % 64'($signed(d)));
        eb = 16'(pr / 64'($signed(d)));
      end
      run(i < 8 ? {i % 2 == 0 ? `OP_PROD : `OP_QUOT, w[11:0]}
          : ext(3'h1, i % 2 == 0 ? `FN_PROD : `FN_QUOT, `MODE_IND), w, c,
          (i < 8 ? `CYC_MD : `CYC_MD_EXT) * `MC_CLKS, 1'b0);
      check16("high", ea, res.a);
      check16("low", eb, res.b);
    end
    $display("test multiply divide done");
    mem_u.mem[15'h0040] = 16'h0000;
    run({`OP_QUOT, 12'h040}, 16'h0000, c, `CYC_MD * `MC_CLKS, 1'b0);
    check16("zdiv_b", ~c.a, res.b);
    check16("zdiv_a", {c.a[15], c.b[14:0]}, res.a);
    bus_rd(`REG_STAT, d);
    check16("stat_ovf", 16'h0002, d & 16'h0003);
    bus_wr(`REG_STAT, 16'h0002);
    #1;
    check16("ovf_clr", 16'h0000, {15'h0000, overflow});
    mem_u.mem[15'h0041] = 16'h0010;
    c.a = 16'h0100;
    run({`OP_QUOT, 12'h041}, 16'h0000, c, `CYC_MD * `MC_CLKS, 1'b0);
    check16("q_ovf", 16'h0001, {15'h0000, overflow});
    $display("test overflow done");
    bus_wr(`REG_CTRL, 16'h0000);
    run(ext(3'h0, 3'h1, 3'h0), 16'h1234, c, 0, 1'b0);
    bus_wr(`REG_CTRL, 16'h0001);
    inhibit <= 1'b1;
    run(ext(3'h0, 3'h1, 3'h0), 16'h1234, c, 0, 1'b0);
    inhibit <= 1'b0;
    run(ext(3'h0, 3'h0, 3'h0), 16'h1234, c, 0, 1'b0);
    $display("test refusal done");
    @(posedge clock);
    instr <= {`OP_PROD, 12'h041};
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b0;
    @(posedge clock);
    rst_b <= 1'b1;
    #1;
    check16("abort", 16'h0000, {14'h0000, busy, overflow});
    bus_rd(`REG_CTRL, d);
    check16("ctrl_again", 16'h0001, d);
    $display("test abort done");
    report_and_stop();
  end
endmodule // multiply_divide_ext_addr_test
`default_nettype wire
